// [pkg/ncac_pkg.sv]
// Constants, register map and carrier types for the note and coin acceptance controller.
// Assumes one 40 MHz clock and an AXI4-Lite register bus with 32-bit data.
// Contract
// - Credit notes only after irrevocable stack message
// - Add note value or credit equivalent
// - Note cheat raises error, disables validator
// - Notes accepted only while play enabled
// - Stacker and link faults disable, report on-line
// - Clear by attendant or new play
// - Stacker door or removal stops play, alarm
// - Validator link is bidirectional
// - Power loss credit window under one second
// - Log last five items, value, time, type (code logs only the note when a note and a coin are credited in one cycle)
// - Coin cheat raises error, disables acceptor
// - Coins accepted only while play enabled
// - Count fast coins, return uncreditable ones (code returns every too_fast coin uncredited and uncounted)
// - Slow or reverse coin shown 30 s
// - Invalid coins to tray, never credited
// - Coin faults: error, disable, alarm, report
// - Divert to hopper, drop box when full
// - Diverter follows detector within ten games
package ncac_pkg;

   // Clock and timing
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned SLOW_SHOW_S     = 30;
   localparam int unsigned SLOW_SHOW_CYC   = SLOW_SHOW_S * CLK_HZ;
   localparam int unsigned DIVERT_GAMES    = 10;
   localparam int unsigned LOG_DEPTH       = 5;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_ERR       = 8'h04;
   localparam logic [7:0] REG_STATUS    = 8'h08;
   localparam logic [7:0] REG_CREDIT    = 8'h0C;
   localparam logic [7:0] REG_DENOM     = 8'h10;
   localparam logic [7:0] REG_CLEAR     = 8'h14;
   localparam logic [7:0] REG_TIME      = 8'h18;
   localparam logic [7:0] REG_LOG_SEL   = 8'h1C;
   localparam logic [7:0] REG_LOG_VAL   = 8'h20;
   localparam logic [7:0] REG_LOG_TIME  = 8'h24;

   // Control register fields
   localparam int CTRL_PLAY_EN   = 0;
   localparam int CTRL_CRED_MODE = 1;
   localparam int CTRL_HOPPER    = 2;
   localparam int CTRL_NEW_PLAY  = 3;

   // Error flag positions
   localparam int ERR_NOTE_CHEAT  = 0;
   localparam int ERR_STK_FULL    = 1;
   localparam int ERR_NOTE_JAM    = 2;
   localparam int ERR_LINK_FAIL   = 3;
   localparam int ERR_STK_DOOR    = 4;
   localparam int ERR_STK_GONE    = 5;
   localparam int ERR_SELF_TEST   = 6;
   localparam int ERR_COIN_CHEAT  = 7;
   localparam int ERR_COIN_JAM    = 8;
   localparam int ERR_RET_JAM     = 9;
   localparam int ERR_COIN_DIR    = 10;
   localparam int ERR_COIN_SPEED  = 11;
   localparam int ERR_W           = 12;

   // Reset values
   localparam logic [31:0] CTRL_RST  = 32'h0000_0004;
   localparam logic [31:0] DENOM_RST = 32'h0000_0001;

   // AXI4-Lite answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Log item kinds
   typedef enum logic [1:0] {ITEM_NOTE, ITEM_COIN} ncac_item_t;

   // One recall log entry
   typedef struct packed {
      ncac_item_t  kind;
      logic [29:0] value;
      logic [31:0] stamp;
   } ncac_entry_t;

   // Validator events from the link receiver
   typedef struct packed {
      logic        stacked;
      logic [29:0] value;
      logic        cheat;
      logic        jam;
      logic        stk_full;
      logic        self_fail;
   } ncac_note_ev_t;

   // Coin path sensor events
   typedef struct packed {
      logic        valid;
      logic        invalid;
      logic        too_fast;
      logic        too_slow;
      logic        reverse;
      logic        cheat;
      logic        jam;
      logic        ret_jam;
      logic [29:0] value;
   } ncac_coin_ev_t;

endpackage

// [sim/ncac_ctrl_tb_top.sv]
// Self-checking bench for the acceptance controller.
// Assumes the partner model owns every sensor pin.
module ncac_ctrl_tb_top;
   import ncac_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_n_i = 0, s_awvalid_i = 0, s_wvalid_i = 0, s_bready_i = 0;
   logic s_arvalid_i = 0, s_rready_i = 0, s_awready_o, s_wready_o, s_bvalid_o;
   logic [7:0]  s_awaddr_i = '0, s_araddr_i = '0;
   logic [31:0] s_wdata_i = '0, s_rdata_o, rv;
   logic [1:0]  bq, rq;
   logic [3:0]  s_wstrb_i = 4'hF;
   logic [1:0]  s_bresp_o, s_rresp_o;
   logic s_arready_o, s_rvalid_o, link_ok_i, stk_door_i, stk_gone_i, hopper_full_i;
   logic game_end_i, note_en_o, coin_en_o, coin_return_o, divert_drop_o;
   logic play_stop_o, alarm_o, online_err_o;
   ncac_note_ev_t note_i;
   ncac_coin_ev_t coin_i;
   int fail_count = 0, tests_run = 0, cyc = 0, rets = 0, n;
   ncac_ctrl #(.SHOW_CYC(50), .GAMES(10)) DUT (.clk_i, .rst_n_i, .s_awaddr_i, .s_awvalid_i,
      .s_awready_o, .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o,
      .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o,
      .s_rvalid_o, .s_rready_i, .note_i, .link_ok_i, .stk_door_i, .stk_gone_i, .note_en_o,
      .coin_i, .hopper_full_i, .game_end_i, .coin_en_o, .coin_return_o, .divert_drop_o,
      .play_stop_o, .alarm_o, .online_err_o);
   ncac_partner P (.clk_i, .note_o(note_i), .coin_o(coin_i), .link_ok_o(link_ok_i),
      .stk_door_o(stk_door_i), .stk_gone_o(stk_gone_i), .hopper_full_o(hopper_full_i),
      .game_end_o(game_end_i));
   // Clock and hang guard
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (coin_return_o) rets++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   task wrap_up();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, s);
      end
   endtask
   // Bus write, each channel released when taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      s_awaddr_i <= a; s_wdata_i <= d;
      s_awvalid_i <= 1; s_wvalid_i <= 1; s_bready_i <= 1;
      do begin
         @(posedge clk_i);
         if (s_awready_o) s_awvalid_i <= 0;
         if (s_wready_o) s_wvalid_i <= 0;
      end while (!s_bvalid_o);
      bq = s_bresp_o;
      s_bready_i <= 0;
      @(posedge clk_i);
   endtask
   task rd(input logic [7:0] a);
      s_araddr_i <= a; s_arvalid_i <= 1; s_rready_i <= 1;
      do begin
         @(posedge clk_i);
         if (s_arready_o) s_arvalid_i <= 0;
      end while (!s_rvalid_o);
      rv = s_rdata_o;
      rq = s_rresp_o;
      s_rready_i <= 0;
      @(posedge clk_i);
   endtask
   task t_credit();
      rd(REG_CTRL); chk("ctrl", rv, CTRL_RST);
      chk("note_en", note_en_o, 0);
      wr(REG_CTRL, 32'h5); repeat (4) @(posedge clk_i);
      chk("note_en", note_en_o, 1);
      P.note(1, 30'h7, 4'h0); rd(REG_CREDIT); chk("credit", rv, 32'h7);
      P.note(0, 30'h9, 4'h0); rd(REG_CREDIT); chk("rejected", rv, 32'h7);
      s_wstrb_i <= 4'h1; wr(REG_DENOM, 32'h0000_0303); s_wstrb_i <= 4'hF;
      rd(REG_DENOM); chk("strb", rv, 32'h3);
      wr(REG_CTRL, 32'h7); n = rets;
      P.coin(8'h80, 30'h2); rd(REG_CREDIT); chk("credit", rv, 32'hD);
      chk("kept", rets, n);
      wr(REG_LOG_SEL, 0); rd(REG_LOG_VAL); chk("log0", rv, 32'h4000_0002);
      wr(REG_LOG_SEL, 1); rd(REG_LOG_VAL); chk("log1", rv, 32'h7);
      n = rets; P.coin(8'h40, 30'h5); rd(REG_CREDIT); chk("invalid", rv, 32'hD);
      chk("tray", rets > n, 1);
      wr(REG_CTRL, 32'h6); n = rets; P.coin(8'h80, 30'h5);
      rd(REG_CREDIT); chk("disabled", rv, 32'hD);
      chk("returned", rets > n, 1);
      wr(REG_LOG_VAL, 32'h0); chk("ro_log", bq, RESP_SLVERR);
      wr(REG_CTRL, 32'h7);
   endtask
   task t_err();
      P.note(0, 30'h0, 4'h4); rd(REG_ERR); chk("err", rv, 32'h4);
      chk("note_en", note_en_o, 0);
      chk("online", online_err_o, 1);
      wr(REG_CLEAR, 32'hFFF); chk("bresp", bq, RESP_OKAY);
      rd(REG_ERR); chk("clr", rv, 0);
      rd(REG_CLEAR); chk("clr_rd", rv, 0);
      chk("rresp", rq, RESP_OKAY);
      P.coin(8'h18, 30'h0); rd(REG_ERR); chk("err", rv, 32'hC00);
      chk("coin_en", coin_en_o, 0);
      wr(REG_CTRL, 32'hF); rd(REG_ERR); chk("held", rv, 32'hC00);
      repeat (60) @(posedge clk_i);
      wr(REG_CTRL, 32'hF); rd(REG_ERR); chk("new_play", rv, 0);
      chk("coin_en", coin_en_o, 1);
      n = rets; P.note(0, 30'h0, 4'hB); P.coin(8'h27, 30'h1);
      rd(REG_ERR); chk("faults", rv, 32'h3C3);
      chk("fast", rets > n, 1);
      chk("alarm", alarm_o, 1);
      wr(REG_CLEAR, 32'hFFF);
      P.pins(5'h18); chk("stop", play_stop_o, 1);
      chk("alarm", alarm_o, 1);
      P.pins(5'h14); chk("gone", play_stop_o, 1);
      P.pins(5'h00); rd(REG_ERR); chk("link", rv, 32'h38);
      P.pins(5'h10); wr(REG_CLEAR, 32'hFFF);
   endtask
   task t_divert();
      P.pins(5'h11); chk("div", divert_drop_o, 0);
      P.pins(5'h12); P.pins(5'h13); chk("div", divert_drop_o, 1);
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1;
      @(posedge clk_i);
      t_credit();
      t_err();
      t_divert();
      wrap_up();
   end
endmodule

// [sim/ncac_partner.sv]
// Validator, coin path and hopper sensor model driving the controller pins.
// Assumes the bench calls its tasks just after a rising clock edge.
module ncac_partner
   import ncac_pkg::*;
(
   // Clock
   input  wire logic    clk_i,
   // Sensor outputs
   output ncac_note_ev_t note_o,
   output ncac_coin_ev_t coin_o,
   output logic          link_ok_o,
   output logic          stk_door_o,
   output logic          stk_gone_o,
   output logic          hopper_full_o,
   output logic          game_end_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle levels, link alive, self-test passed
   initial begin
      note_o = '0;
      coin_o = '0;
      {link_ok_o, stk_door_o, stk_gone_o, hopper_full_o, game_end_o} = 5'h10;
   end
   // Stack message or fault flags {cheat,jam,full,self}, value inverted on release
   // A rejected note never raises stacked and goes back to the player
   task note(input logic s, input logic [29:0] v, input logic [3:0] e);
      note_o <= {1'b0, v, 4'h0};
      @(posedge clk_i);
      note_o <= {s, v, e};
      repeat (3) @(posedge clk_i);
      note_o <= {1'b0, ~v, 4'h0};
      repeat (6) @(posedge clk_i);
   endtask
   // Coin strobe with flags {valid..ret_jam}
   task coin(input logic [7:0] f, input logic [29:0] v);
      coin_o <= {8'h00, v};
      @(posedge clk_i);
      coin_o <= {f, v};
      repeat (3) @(posedge clk_i);
      coin_o <= {8'h00, ~v};
      repeat (6) @(posedge clk_i);
   endtask
   // Levels {link_ok,door,gone,hopper_full,game_end}
   task pins(input logic [4:0] p);
      {link_ok_o, stk_door_o, stk_gone_o, hopper_full_o, game_end_o} <= p;
      repeat (6) @(posedge clk_i);
   endtask
endmodule

// [src/ncac_ctrl.sv]
// Note and coin acceptance controller: credits, sticky errors, diverter, log, AXI4-Lite.
// Assumes validator and coin sensors are asynchronous pins; events are
// single cycle pulses after synchronisation (strobes are level flags held
// by the sender at least two cycles; value lines are stable when seen).
module ncac_ctrl
   import ncac_pkg::*;
#(
   parameter int unsigned SHOW_CYC = SLOW_SHOW_CYC,
   parameter int unsigned GAMES    = DIVERT_GAMES
) (
   // Clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_n_i,
   // AXI4-Lite slave
   input  wire logic [7:0]    s_awaddr_i,
   input  wire logic          s_awvalid_i,
   output logic               s_awready_o,
   input  wire logic [31:0]   s_wdata_i,
   input  wire logic [3:0]    s_wstrb_i,
   input  wire logic          s_wvalid_i,
   output logic               s_wready_o,
   output logic [1:0]         s_bresp_o,
   output logic               s_bvalid_o,
   input  wire logic          s_bready_i,
   input  wire logic [7:0]    s_araddr_i,
   input  wire logic          s_arvalid_i,
   output logic               s_arready_o,
   output logic [31:0]        s_rdata_o,
   output logic [1:0]         s_rresp_o,
   output logic               s_rvalid_o,
   input  wire logic          s_rready_i,
   // Validator link and stacker sensors
   input  wire ncac_note_ev_t note_i,
   input  wire logic          link_ok_i,
   input  wire logic          stk_door_i,
   input  wire logic          stk_gone_i,
   output logic               note_en_o,
   // Coin path and diverter
   input  wire ncac_coin_ev_t coin_i,
   input  wire logic          hopper_full_i,
   input  wire logic          game_end_i,
   output logic               coin_en_o,
   output logic               coin_return_o,
   output logic               divert_drop_o,
   // Machine signals
   output logic               play_stop_o,
   output logic               alarm_o,
   output logic               online_err_o
);

   // Pin synchronisers, two flops each
   localparam int SW = $bits(ncac_note_ev_t) + $bits(ncac_coin_ev_t) + 5;
   logic [SW-1:0] sync1_reg;
   logic [SW-1:0] sync2_reg;
   logic [SW-1:0] prev_reg;
   // Link-alive line idles high: reset it high so no false link fault follows reset
   localparam int            LINK_OK_POS = 4;
   localparam logic [SW-1:0] SYNC_RST    = SW'(1) << LINK_OK_POS;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_reg <= SYNC_RST;
         sync2_reg <= SYNC_RST;
         prev_reg  <= SYNC_RST;
      end else begin
         sync1_reg <= {note_i, coin_i, link_ok_i, stk_door_i, stk_gone_i, hopper_full_i,
                       game_end_i};
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   ncac_note_ev_t note_s;
   ncac_coin_ev_t coin_s;
   ncac_coin_ev_t coin_p;
   logic          link_ok_s, stk_door_s, stk_gone_s, hfull_s, game_end_s, game_end_p;
   ncac_note_ev_t note_p;
   assign {note_s, coin_s, link_ok_s, stk_door_s, stk_gone_s, hfull_s, game_end_s} = sync2_reg;
   assign {note_p, coin_p} = prev_reg[SW-1:5];
   assign game_end_p = prev_reg[0];

   // Rising edges of event strobes
   logic stack_ev, coin_ok_ev, game_ev;
   assign stack_ev   = note_s.stacked & ~note_p.stacked;
   assign coin_ok_ev = coin_s.valid & ~coin_p.valid;
   assign game_ev    = game_end_s & ~game_end_p;

   // Registers
   logic [31:0]       ctrl_reg;
   logic [31:0]       denom_reg;
   logic [31:0]       credit_reg;
   logic [31:0]       time_reg;
   logic [2:0]        log_sel_reg;
   logic [ERR_W-1:0]  err_reg;
   logic [ERR_W-1:0]  err_src;
   logic [ERR_W-1:0]  err_clr;
   logic              play_en, enabled;

   assign play_en = ctrl_reg[CTRL_PLAY_EN];
   // Acceptance only in play with no flag and doors shut
   assign enabled = play_en & ~|err_reg & ~stk_door_s & ~stk_gone_s;

   // Live error sources
   always_comb begin
      err_src                 = '0;
      err_src[ERR_NOTE_CHEAT] = note_s.cheat;
      err_src[ERR_STK_FULL]   = note_s.stk_full;
      err_src[ERR_NOTE_JAM]   = note_s.jam;
      err_src[ERR_LINK_FAIL]  = ~link_ok_s;
      err_src[ERR_STK_DOOR]   = stk_door_s;
      err_src[ERR_STK_GONE]   = stk_gone_s;
      err_src[ERR_SELF_TEST]  = note_s.self_fail;
      err_src[ERR_COIN_CHEAT] = coin_s.cheat;
      err_src[ERR_COIN_JAM]   = coin_s.jam;
      err_src[ERR_RET_JAM]    = coin_s.ret_jam;
      err_src[ERR_COIN_DIR]   = coin_s.reverse;
      err_src[ERR_COIN_SPEED] = coin_s.too_slow;
   end

   // Slow or reverse coin display hold timer
   logic [31:0] show_cnt_reg;
   logic        show_busy;
   assign show_busy = show_cnt_reg != '0;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         show_cnt_reg <= '0;
      end else if (coin_s.too_slow | coin_s.reverse) begin
         show_cnt_reg <= SHOW_CYC;
      end else if (show_busy) begin
         show_cnt_reg <= show_cnt_reg - 32'h0000_0001;
      end
   end

   // Write channel handshakes
   logic        aw_hold_reg, w_hold_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        wr_go;
   assign s_awready_o = ~aw_hold_reg & ~s_bvalid_o;
   assign s_wready_o  = ~w_hold_reg & ~s_bvalid_o;
   assign wr_go       = aw_hold_reg & w_hold_reg & ~s_bvalid_o;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg  <= '0;
         w_strb_reg  <= '0;
         s_bvalid_o  <= 1'b0;
         s_bresp_o   <= RESP_OKAY;
      end else begin
         if (s_awvalid_i && s_awready_o) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_awaddr_i;
         end
         if (s_wvalid_i && s_wready_o) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_wdata_i;
            w_strb_reg <= s_wstrb_i;
         end
         if (wr_go) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            s_bvalid_o  <= 1'b1;
            s_bresp_o   <= (aw_addr_reg[7:2] <= REG_LOG_SEL[7:2]) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_bvalid_o && s_bready_i) begin
            s_bvalid_o <= 1'b0;
         end
      end
   end

   // Byte-lane merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return merge_ret(r);
   endfunction
   function automatic logic [31:0] merge_ret(input logic [31:0] v);
      return v;
   endfunction

   logic wr_ctrl, wr_denom, wr_clear, wr_time, wr_sel;
   assign wr_ctrl  = wr_go && aw_addr_reg == REG_CTRL;
   assign wr_denom = wr_go && aw_addr_reg == REG_DENOM;
   assign wr_clear = wr_go && aw_addr_reg == REG_CLEAR;
   assign wr_time  = wr_go && aw_addr_reg == REG_TIME;
   assign wr_sel   = wr_go && aw_addr_reg == REG_LOG_SEL;

   // Software-written configuration
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_reg    <= CTRL_RST;
         denom_reg   <= DENOM_RST;
         log_sel_reg <= '0;
      end else begin
         if (wr_ctrl)  ctrl_reg    <= merge(ctrl_reg, w_data_reg, w_strb_reg);
         if (wr_denom) denom_reg   <= merge(denom_reg, w_data_reg, w_strb_reg);
         if (wr_sel)   log_sel_reg <= w_data_reg[2:0];
      end
   end

   // Free-running timestamp, software may load it
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         time_reg <= '0;
      end else if (wr_time) begin
         time_reg <= merge(time_reg, w_data_reg, w_strb_reg);
      end else begin
         time_reg <= time_reg + 32'h0000_0001;
      end
   end

   // New play start clears gone conditions, except slow and reverse flags while shown; attendant clears by mask
   logic new_play;
   assign new_play = wr_ctrl && w_data_reg[CTRL_NEW_PLAY] && w_strb_reg[0];
   always_comb begin
      err_clr = '0;
      if (wr_clear) err_clr = w_data_reg[ERR_W-1:0];
      if (new_play) err_clr = err_clr | ~err_src;
      if (show_busy && !wr_clear) begin
         err_clr[ERR_COIN_DIR]   = 1'b0;
         err_clr[ERR_COIN_SPEED] = 1'b0;
      end
   end

   // Sticky error flags, set wins over clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         err_reg <= '0;
      end else begin
         err_reg <= (err_reg & ~err_clr) | err_src;
      end
   end

   // Credit meter, note on stacked message only coin when valid
   logic [31:0] note_add, coin_add;
   logic        note_cred, coin_cred;
   assign note_add  = ctrl_reg[CTRL_CRED_MODE] ? 32'(note_s.value) * denom_reg
                                               : 32'(note_s.value);
   assign coin_add  = ctrl_reg[CTRL_CRED_MODE] ? 32'(coin_s.value) * denom_reg
                                               : 32'(coin_s.value);
   assign note_cred = stack_ev;
   assign coin_cred = coin_ok_ev & enabled & ~coin_s.invalid & ~coin_s.too_fast;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         credit_reg <= '0;
      end else begin
         credit_reg <= credit_reg + (note_cred ? note_add : '0) + (coin_cred ? coin_add : '0);
      end
   end

   // Coin return gate for invalid, fast or unaccepted coins
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         coin_return_o <= 1'b0;
      end else begin
         coin_return_o <= coin_s.invalid | coin_s.too_fast | (coin_s.valid & ~enabled);
      end
   end

   // Recall log push; note wins, a coin in the same cycle is rare
   ncac_entry_t log_in, log_out;
   always_comb begin
      log_in.kind  = note_cred ? ITEM_NOTE : ITEM_COIN;
      log_in.value = note_cred ? note_s.value : coin_s.value;
      log_in.stamp = time_reg;
   end
   ncac_log #(.DEPTH(LOG_DEPTH)) u_log (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .push_i  (note_cred | coin_cred),
      .entry_i (log_in),
      .sel_i   (log_sel_reg),
      .entry_o (log_out)
   );

   // Diverter: follows detector at a game end with no coin in the path,
   // or at the last allowed game end regardless
   logic [3:0] game_cnt_reg;
   logic       want_drop;
   assign want_drop = ~ctrl_reg[CTRL_HOPPER] | hfull_s;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         divert_drop_o <= 1'b1;
         game_cnt_reg  <= '0;
      end else if (!ctrl_reg[CTRL_HOPPER]) begin
         divert_drop_o <= 1'b1;
         game_cnt_reg  <= '0;
      end else if (want_drop != divert_drop_o) begin
         if (game_ev && (!coin_s.valid || 32'(game_cnt_reg) >= GAMES - 1)) begin
            divert_drop_o <= want_drop;
            game_cnt_reg  <= '0;
         end else if (game_ev) begin
            game_cnt_reg  <= game_cnt_reg + 4'h1;                 // Deferred game
         end
      end else begin
         game_cnt_reg <= '0;
      end
   end

   // Machine outputs
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         note_en_o    <= 1'b0;
         coin_en_o    <= 1'b0;
         play_stop_o  <= 1'b1;
         alarm_o      <= 1'b0;
         online_err_o <= 1'b0;
      end else begin
         note_en_o    <= enabled;
         coin_en_o    <= enabled;
         play_stop_o  <= ~play_en | stk_door_s | stk_gone_s;
         alarm_o      <= |err_reg | stk_door_s | stk_gone_s;
         online_err_o <= |err_reg;
      end
   end

   // Read channel
   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      unique case (s_araddr_i)
         REG_CTRL:     rd_mux = ctrl_reg;
         REG_ERR:      rd_mux = 32'(err_reg);
         REG_STATUS:   rd_mux = {28'h0, divert_drop_o, show_busy, coin_en_o, note_en_o};
         REG_CREDIT:   rd_mux = credit_reg;
         REG_DENOM:    rd_mux = denom_reg;
         REG_TIME:     rd_mux = time_reg;
         REG_LOG_SEL:  rd_mux = 32'(log_sel_reg);
         REG_LOG_VAL:  rd_mux = {log_out.kind, log_out.value};
         REG_LOG_TIME: rd_mux = log_out.stamp;
         default: begin
            rd_mux = '0;
            rd_hit = s_araddr_i == REG_CLEAR;
         end
      endcase
   end

   assign s_arready_o = ~s_rvalid_o;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_rvalid_o <= 1'b0;
         s_rdata_o  <= '0;
         s_rresp_o  <= RESP_OKAY;
      end else if (s_arvalid_i && s_arready_o) begin
         s_rvalid_o <= 1'b1;
         s_rdata_o  <= rd_mux;
         s_rresp_o  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_rvalid_o && s_rready_i) begin
         s_rvalid_o <= 1'b0;
      end
   end

   // Checks
   sequence s_door;
      stk_door_s | stk_gone_s;
   endsequence
   property p_door_stop;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_door |=> (play_stop_o && alarm_o && !note_en_o);
   endproperty
   a_door_stop: assert property (p_door_stop) else $error("door did not stop play");

   property p_note_only_stacked;
      @(posedge clk_i) disable iff (!rst_n_i)
      (!note_cred && !coin_cred) |=> (credit_reg == $past(credit_reg));
   endproperty
   a_note_only_stacked: assert property (p_note_only_stacked) else $error("credit moved");

   property p_note_value;
      @(posedge clk_i) disable iff (!rst_n_i)
      (note_cred && !coin_cred) |=> (credit_reg == $past(credit_reg) + $past(note_add));
   endproperty
   a_note_value: assert property (p_note_value) else $error("note value wrong");

   property p_invalid_coin;
      @(posedge clk_i) disable iff (!rst_n_i)
      coin_s.invalid |-> !coin_cred ##1 coin_return_o;
   endproperty
   a_invalid_coin: assert property (p_invalid_coin) else $error("invalid coin credited");

   property p_fast_coin;
      @(posedge clk_i) disable iff (!rst_n_i)
      coin_s.too_fast |=> coin_return_o;
   endproperty
   a_fast_coin: assert property (p_fast_coin) else $error("fast coin kept");

   property p_err_disable;
      @(posedge clk_i) disable iff (!rst_n_i)
      (|err_reg) |=> (!note_en_o && !coin_en_o);
   endproperty
   a_err_disable: assert property (p_err_disable) else $error("enabled with error");

   property p_no_play;
      @(posedge clk_i) disable iff (!rst_n_i)
      !play_en |=> (!note_en_o && !coin_en_o);
   endproperty
   a_no_play: assert property (p_no_play) else $error("enabled out of play");

   property p_cheat_flag;
      @(posedge clk_i) disable iff (!rst_n_i)
      (note_s.cheat || coin_s.cheat) |=> (err_reg[ERR_NOTE_CHEAT] || err_reg[ERR_COIN_CHEAT])
         ##1 !coin_en_o;
   endproperty
   a_cheat_flag: assert property (p_cheat_flag) else $error("cheat not flagged");

   property p_slow_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      (err_reg[ERR_COIN_SPEED] && show_busy && !wr_clear) |=> err_reg[ERR_COIN_SPEED];
   endproperty
   a_slow_hold: assert property (p_slow_hold) else $error("slow coin error dropped");

   property p_no_hopper;
      @(posedge clk_i) disable iff (!rst_n_i)
      !ctrl_reg[CTRL_HOPPER] |=> divert_drop_o;
   endproperty
   a_no_hopper: assert property (p_no_hopper) else $error("hopperless not to drop box");

endmodule

// [src/ncac_log.sv]
// Recall log of the most recently accepted items.
// Assumes single-cycle push pulses on the controller clock.
module ncac_log
   import ncac_pkg::*;
#(
   parameter int unsigned DEPTH = LOG_DEPTH
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Push side
   input  wire logic        push_i,
   input  wire ncac_entry_t entry_i,
   // Read side, 0 is the newest
   input  wire logic [2:0]  sel_i,
   output ncac_entry_t      entry_o
);

   ncac_entry_t mem_reg [DEPTH];

   // Shift in newest entry
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
      end else if (push_i) begin
         mem_reg[0] <= entry_i;
         for (int i = 1; i < DEPTH; i++) begin
            mem_reg[i] <= mem_reg[i-1];
         end
      end
   end

   // Registered read port
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         entry_o <= '0;
      end else if (32'(sel_i) < DEPTH) begin
         entry_o <= mem_reg[sel_i];
      end else begin
         entry_o <= '0;
      end
   end

   // Newest entry appears one cycle after a push
   property p_log_push;
      @(posedge clk_i) disable iff (!rst_n_i)
      push_i |=> (mem_reg[0] == $past(entry_i));
   endproperty
   a_log_push: assert property (p_log_push) else $error("log push lost");

endmodule
